// file: sac_pkg.sv
// How it works
// - Result pin floats unless chip select low.
// - Chip select low shows previous result MSB.
// - Result changes falling in micro, rising DSP.
// - Busy flag falls on tenth handoff edge.
// - Busy flag stays low until result ready.
// - Invert pin can also enter test mode.
// - Micro, invert high: command on rises.
// - Micro, invert low: command on falls.
// - Micro samples fourth fall to tenth rise.
// - Micro output bits change on nine falls.
// - Micro hands conversion over on tenth rise.
// - DSP, invert high: command on falls.
// - DSP, invert low: command on rises.
// - DSP samples fourth rise to tenth fall.
// - DSP output bits change on ten rises.
// - DSP hands conversion over on tenth fall.
// - Chip select fall latches host type.
// - Chip select fall resets counters, enables pins.
// - Start pin falling samples, rising converts.
// - Data input ignored after four command bits.
package sac_pkg;

  localparam int unsigned SAC_RES_BITS    = 10;
  localparam int unsigned SAC_CMD_BITS    = 4;
  localparam int unsigned SAC_CNT_W       = 5;
  localparam logic [4:0]  SAC_CNT_MAX     = 5'h1f;
  localparam logic [4:0]  SAC_CMD_EDGES   = 5'h04;
  localparam logic [4:0]  SAC_SAMPLE_EDGE = 5'h04;
  localparam logic [4:0]  SAC_HAND_EDGE   = 5'h0a;
  localparam logic [4:0]  SAC_OUT_EDGES   = 5'h0a;
  localparam logic [9:0]  SAC_RESULT_RST  = 10'h000;
  localparam logic [3:0]  SAC_CMD_RST     = 4'h0;
  localparam int unsigned SAC_SYNC_STAGES = 2;

  typedef enum logic [1:0] {
    SAC_IDLE,
    SAC_SAMPLE,
    SAC_CONVERT
  } sac_state_e;

endpackage : sac_pkg

// file: sac_sync.sv
`timescale 1ns/1ps
module sac_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  import sac_pkg::*;

  logic [WIDTH-1:0] meta_r;

  // First stage feeds only the second one
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r   <= '0;
      sync_out <= '0;
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule : sac_sync

// file: sac_top.sv
`timescale 1ns/1ps
module sac_top #(
  parameter int unsigned RES_BITS = sac_pkg::SAC_RES_BITS,
  parameter int unsigned CMD_BITS = sac_pkg::SAC_CMD_BITS
) (
  input  wire logic                core_clk,
  input  wire logic                sys_rst,
  input  wire logic                io_clk,
  input  wire logic                cs_n,
  input  wire logic                frame_sync,
  input  wire logic                edge_invert,
  input  wire logic                data_in,
  input  wire logic                sample_start_n,
  output logic                     data_out_o,
  output logic                     data_out_oe,
  output logic                     eoc,
  output logic                     sampling,
  output logic                     conv_start,
  output logic [CMD_BITS-1:0]      mux_addr,
  output logic                     test_mode,
  input  wire logic                conv_done,
  input  wire logic [RES_BITS-1:0] conv_data
);
  import sac_pkg::*;

  generate
    if (RES_BITS != SAC_RES_BITS || CMD_BITS != SAC_CMD_BITS) begin : g_chk
      $error("sac_top: only 10 result bits and 4 command bits supported");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Link side, clocked by the host serial clock on both edges.
  // Chip select high holds the edge counters and command shifts in reset.
  // ---------------------------------------------------------------
  logic                 mode_mp_r;
  logic [SAC_CNT_W-1:0] rise_cnt_r;
  logic [SAC_CNT_W-1:0] fall_cnt_r;
  logic [CMD_BITS-1:0]  cmd_rise_r;
  logic [CMD_BITS-1:0]  cmd_fall_r;
  logic                 samp_tgl_rise_r;
  logic                 samp_tgl_fall_r;
  logic                 hand_tgl_rise_r;
  logic                 hand_tgl_fall_r;
  logic                 frame_clr;
  logic                 cap_on_rise;
  logic [CMD_BITS-1:0]  cmd_link;

  // Host type caught at the chip select fall
  always_ff @(negedge cs_n) begin
    mode_mp_r <= frame_sync;
  end

  // DSP host re-arms the frame while frame sync is high
  assign frame_clr   = !mode_mp_r && frame_sync;
  // Micro+invert high or DSP+invert low capture on rising edges
  assign cap_on_rise = (mode_mp_r == edge_invert);
  assign cmd_link    = cap_on_rise ? cmd_rise_r : cmd_fall_r;

  always_ff @(posedge io_clk or posedge cs_n) begin
    if (cs_n) begin
      rise_cnt_r <= '0;
    end else if (frame_clr) begin
      rise_cnt_r <= '0;
    end else if (rise_cnt_r != SAC_CNT_MAX) begin
      rise_cnt_r <= rise_cnt_r + 5'h01;
    end
  end

  always_ff @(negedge io_clk or posedge cs_n) begin
    if (cs_n) begin
      fall_cnt_r <= '0;
    end else if (frame_clr) begin
      fall_cnt_r <= '0;
    end else if (fall_cnt_r != SAC_CNT_MAX) begin
      fall_cnt_r <= fall_cnt_r + 5'h01;
    end
  end

  // Command shift, MSB first; input ignored after four bits
  always_ff @(posedge io_clk or posedge cs_n) begin
    if (cs_n) begin
      cmd_rise_r <= SAC_CMD_RST;
    end else if (!frame_clr && rise_cnt_r < SAC_CMD_EDGES) begin
      cmd_rise_r <= {cmd_rise_r[CMD_BITS-2:0], data_in};
    end
  end

  always_ff @(negedge io_clk or posedge cs_n) begin
    if (cs_n) begin
      cmd_fall_r <= SAC_CMD_RST;
    end else if (!frame_clr && fall_cnt_r < SAC_CMD_EDGES) begin
      cmd_fall_r <= {cmd_fall_r[CMD_BITS-2:0], data_in};
    end
  end

  // Event toggles. These survive chip select so that a toggle
  // already sent is never taken back before the core sees it.
  always_ff @(posedge io_clk or posedge sys_rst) begin
    if (sys_rst) begin
      samp_tgl_rise_r <= 1'b0;
      hand_tgl_rise_r <= 1'b0;
    end else if (!cs_n && !frame_clr) begin
      if (!mode_mp_r && rise_cnt_r == SAC_SAMPLE_EDGE - 5'h01) begin
        samp_tgl_rise_r <= !samp_tgl_rise_r;
      end
      if (mode_mp_r && rise_cnt_r == SAC_HAND_EDGE - 5'h01) begin
        hand_tgl_rise_r <= !hand_tgl_rise_r;
      end
    end
  end

  always_ff @(negedge io_clk or posedge sys_rst) begin
    if (sys_rst) begin
      samp_tgl_fall_r <= 1'b0;
      hand_tgl_fall_r <= 1'b0;
    end else if (!cs_n && !frame_clr) begin
      if (mode_mp_r && fall_cnt_r == SAC_SAMPLE_EDGE - 5'h01) begin
        samp_tgl_fall_r <= !samp_tgl_fall_r;
      end
      if (!mode_mp_r && fall_cnt_r == SAC_HAND_EDGE - 5'h01) begin
        hand_tgl_fall_r <= !hand_tgl_fall_r;
      end
    end
  end

  // Result bit selection. Micro steps on falls, DSP on rises;
  // DSP repeats the MSB on its first rise, then pads zeros.
  logic [SAC_CNT_W-1:0] out_cnt;
  logic [SAC_CNT_W-1:0] out_idx;
  logic                 out_bit;
  logic [RES_BITS-1:0]  result_r;

  assign out_cnt = mode_mp_r ? fall_cnt_r : rise_cnt_r;

  always_comb begin
    out_idx = '0;
    out_bit = 1'b0;
    if (out_cnt == '0) begin
      out_bit = result_r[RES_BITS-1];
    end else if (mode_mp_r && out_cnt < SAC_OUT_EDGES) begin
      out_idx = 5'(RES_BITS - 1) - out_cnt;
      out_bit = result_r[out_idx[3:0]];
    end else if (!mode_mp_r && out_cnt <= SAC_OUT_EDGES) begin
      out_idx = 5'(RES_BITS) - out_cnt;
      out_bit = result_r[out_idx[3:0]];
    end
  end

  // Pin must follow chip select with no clock running, so the
  // enable and the data are decoded rather than registered.
  assign data_out_o  = cs_n ? 1'b0 : out_bit;
  assign data_out_oe = !cs_n;

  // ---------------------------------------------------------------
  // Core side on core_clk
  // ---------------------------------------------------------------
  logic       samp_tgl;
  logic       hand_tgl;
  logic [4:0] async_vec;
  logic [4:0] sync_vec;
  logic       samp_s;
  logic       hand_s;
  logic       sstart_n_s;
  logic       inv_s;
  logic       cs_n_s;

  // Only one toggle of each pair moves at a time, so the xor
  // cannot glitch into a false event.
  assign samp_tgl  = samp_tgl_rise_r ^ samp_tgl_fall_r;
  assign hand_tgl  = hand_tgl_rise_r ^ hand_tgl_fall_r;
  assign async_vec = {cs_n, edge_invert, sample_start_n, hand_tgl,
                      samp_tgl};

  sac_sync #(
    .WIDTH (5)
  ) u_sync (
    .clk      (core_clk),
    .rst      (sys_rst),
    .async_in (async_vec),
    .sync_out (sync_vec)
  );

  assign samp_s     = sync_vec[0];
  assign hand_s     = sync_vec[1];
  assign sstart_n_s = sync_vec[2];
  assign inv_s      = sync_vec[3];
  assign cs_n_s     = sync_vec[4];

  logic samp_d_r;
  logic hand_d_r;
  logic sstart_d_r;
  logic inv_d_r;
  logic cs_d_r;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      samp_d_r   <= 1'b0;
      hand_d_r   <= 1'b0;
      // Cleared like the synchroniser: no false fall after reset, but the idle-high pin gives one false rise
      sstart_d_r <= 1'b0;
      inv_d_r    <= 1'b0;
      cs_d_r     <= 1'b0;
    end else begin
      samp_d_r   <= samp_s;
      hand_d_r   <= hand_s;
      sstart_d_r <= sstart_n_s;
      inv_d_r    <= inv_s;
      cs_d_r     <= cs_n_s;
    end
  end

  logic samp_evt;
  logic hand_evt;
  logic sstart_fall;
  logic sstart_rise;

  assign samp_evt    = samp_s ^ samp_d_r;
  assign hand_evt    = hand_s ^ hand_d_r;
  assign sstart_fall = sstart_d_r && !sstart_n_s;
  assign sstart_rise = !sstart_d_r && sstart_n_s;

  sac_state_e state_r;
  logic       ext_r;

  // Conversion sequencer; sample start works regardless of
  // chip select and the serial clock.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_r <= SAC_IDLE;
      ext_r   <= 1'b0;
    end else begin
      case (state_r)
        SAC_IDLE: begin
          if (sstart_fall) begin
            state_r <= SAC_SAMPLE;
            ext_r   <= 1'b1;
          end else if (hand_evt) begin
            state_r <= SAC_CONVERT;
          end else if (samp_evt) begin
            state_r <= SAC_SAMPLE;
          end
        end
        SAC_SAMPLE: begin
          if (ext_r && sstart_rise) begin
            state_r <= SAC_CONVERT;
            ext_r   <= 1'b0;
          end else if (!ext_r && hand_evt) begin
            state_r <= SAC_CONVERT;
          end
        end
        SAC_CONVERT: begin
          if (conv_done) begin
            state_r <= SAC_IDLE;
          end
        end
        default: begin
          state_r <= SAC_IDLE;
          ext_r   <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sampling <= 1'b0;
    end else begin
      sampling <= (state_r == SAC_SAMPLE);
    end
  end

  // Every path into conversion in one place, so the start pulse
  // and the busy flag can never disagree. A serial handoff during
  // extended sampling is ignored and must not drop busy.
  logic conv_go;

  always_comb begin
    conv_go = 1'b0;
    case (state_r)
      SAC_IDLE: begin
        conv_go = hand_evt && !sstart_fall;
      end
      SAC_SAMPLE: begin
        if (ext_r) begin
          conv_go = sstart_rise;
        end else begin
          conv_go = hand_evt;
        end
      end
      default: begin
        conv_go = 1'b0;
      end
    endcase
  end

  // One-cycle kick to the converter core on entering conversion
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      conv_start <= 1'b0;
    end else begin
      conv_start <= conv_go;
    end
  end

  // Busy from the conversion kick until the core reports done
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      eoc <= 1'b1;
    end else if (conv_go) begin
      eoc <= 1'b0;
    end else if (state_r == SAC_CONVERT && conv_done) begin
      eoc <= 1'b1;
    end
  end

  // Result word is only rewritten at conversion end; host must
  // not lower chip select right at that moment.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      result_r <= SAC_RESULT_RST;
    end else if (state_r == SAC_CONVERT && conv_done) begin
      result_r <= conv_data;
    end
  end

  // Command is stable by the sample event, so the toggle acts as
  // the handshake for the word.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mux_addr <= SAC_CMD_RST;
    end else if (samp_evt) begin
      mux_addr <= cmd_link;
    end
  end

  // Test mode: invert pin moved while chip select is low.
  // Waits a cycle past select so a pre-frame pin change is not one.
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      test_mode <= 1'b0;
    end else if (cs_n_s && !cs_d_r) begin
      test_mode <= 1'b0;
    end else if (!cs_n_s && !cs_d_r && (inv_s != inv_d_r)) begin
      test_mode <= 1'b1;
    end
  end

endmodule : sac_top

// file: sac_props.sv
`timescale 1ns/1ps
module sac_props #(
  parameter int unsigned CMD_BITS = 4
) (
  input wire logic                core_clk,
  input wire logic                sys_rst,
  input wire logic                cs_n,
  input wire logic                sample_start_n,
  input wire logic                data_out_oe,
  input wire logic                eoc,
  input wire logic                sampling,
  input wire logic                conv_start,
  input wire logic [CMD_BITS-1:0] mux_addr,
  input wire logic                test_mode,
  input wire logic                conv_done
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_busy;
    !eoc && !conv_done;
  endsequence
  sequence s_ext;
    $fell(sample_start_n) && eoc && !sampling;
  endsequence

  property p_rst;
    disable iff (1'b0)
    sys_rst [*2] |-> eoc && !sampling && !conv_start && !(|mux_addr);
  endproperty
  property p_oe;      data_out_oe == !cs_n;                endproperty
  property p_hold;    s_busy |=> !eoc;                      endproperty
  property p_done;    !eoc && conv_done |=> eoc;            endproperty
  property p_pulse;   conv_start |=> !conv_start;           endproperty
  property p_busy;    conv_start |-> ##[0:1] !eoc;          endproperty
  property p_ext;     s_ext |-> ##[1:6] sampling;           endproperty
  property p_ext_cnv;
    $rose(sample_start_n) && sampling |-> ##[1:6] conv_start;
  endproperty
  // Garbage after the command must not reach the address
  property p_addr;
    sampling && $past(sampling, 3) |-> $stable(mux_addr);
  endproperty
  property p_test;    cs_n [*5] |-> !test_mode;             endproperty

  a_rst: assert property (p_rst) else $error("bad reset values");
  a_oe: assert property (p_oe) else $error("enable not !cs_n");
  a_hold: assert property (p_hold) else $error("eoc rose early");
  a_done: assert property (p_done) else $error("eoc stuck low");
  a_pulse: assert property (p_pulse) else $error("start too long");
  a_busy: assert property (p_busy) else $error("no busy at start");
  a_ext: assert property (p_ext) else $error("no sampling");
  a_ext_cnv: assert property (p_ext_cnv) else $error("no convert");
  a_addr: assert property (p_addr) else $error("address moved");
  a_test: assert property (p_test) else $error("test mode stuck");
endmodule : sac_props

bind sac_top sac_props #(.CMD_BITS(CMD_BITS)) u_props (
  .core_clk(core_clk), .sys_rst(sys_rst), .cs_n(cs_n),
  .sample_start_n(sample_start_n), .data_out_oe(data_out_oe), .eoc(eoc),
  .sampling(sampling), .conv_start(conv_start), .mux_addr(mux_addr),
  .test_mode(test_mode), .conv_done(conv_done)
);

// file: sac_host.sv
`timescale 1ns/1ps
module sac_host (
  output logic io_clk,
  output logic cs_n,
  output logic frame_sync,
  output logic edge_invert,
  output logic data_in,
  input  wire logic data_out_o
);
  logic [9:0] got;
  initial begin
    io_clk = 1'b0;
    cs_n = 1'b1;
    frame_sync = 1'b1;
    edge_invert = 1'b1;
    data_in = 1'b0;
  end
  // Clock stands still between frames; 6 ns per cycle inside
  task automatic frame(input logic dsp, input logic inv,
                       input logic [3:0] cmd);
    int k;
    edge_invert = inv;
    frame_sync = !dsp;
    #5 cs_n = 1'b0;
    #5;
    if (dsp) begin
      frame_sync = 1'b1;
      #3 io_clk = 1'b1;
      #3 io_clk = 1'b0;
      #1 frame_sync = 1'b0;
    end
    for (k = 1; k <= 10; k++) begin
      // Past the command the line keeps toggling
      #1 data_in = (k <= 4) ? cmd[4-k] : k[0];
      #2 if (!dsp) got[10-k] = data_out_o;
      io_clk = 1'b1;
      #3 if (dsp) got[10-k] = data_out_o;
      io_clk = 1'b0;
    end
    #5 cs_n = 1'b1;
    frame_sync = 1'b1;
    #1;
  endtask : frame
  // Invert pin flipped while selected, no clock running
  task automatic poke_invert();
    frame_sync = 1'b1;
    #5 cs_n = 1'b0;
    #40 edge_invert = !edge_invert;
    #40;
  endtask : poke_invert
  task automatic deselect();
    cs_n = 1'b1;
    #1;
  endtask : deselect
endmodule : sac_host

// file: tb.sv
`timescale 1ns/1ps
module tb;
  import sac_pkg::*;
  typedef struct {
    logic       dsp;
    logic       inv;
    logic [3:0] cmd;
    logic [9:0] res;
  } sac_row_s;
  logic       core_clk, sys_rst, sample_start_n, conv_done;
  logic [9:0] conv_data, prev;
  wire        io_clk, cs_n, frame_sync, edge_invert, data_in;
  wire        data_out_o, data_out_oe, eoc, sampling, conv_start, test_mode;
  wire  [3:0] mux_addr;
  int         n_mismatch = 0;
  int         checks_done = 0;
  int         cyc = 0;
  sac_row_s   rows[4] = '{'{1'b0, 1'b1, 4'ha, 10'h2b5},
                          '{1'b0, 1'b0, 4'h5, 10'h3c1},
                          '{1'b1, 1'b1, 4'hc, 10'h04e},
                          '{1'b1, 1'b0, 4'h3, 10'h1f9}};

  sac_top uut (
    .core_clk(core_clk), .sys_rst(sys_rst), .io_clk(io_clk), .cs_n(cs_n),
    .frame_sync(frame_sync), .edge_invert(edge_invert), .data_in(data_in),
    .sample_start_n(sample_start_n), .data_out_o(data_out_o),
    .data_out_oe(data_out_oe), .eoc(eoc), .sampling(sampling),
    .conv_start(conv_start), .mux_addr(mux_addr), .test_mode(test_mode),
    .conv_done(conv_done), .conv_data(conv_data)
  );
  sac_host host (
    .io_clk(io_clk), .cs_n(cs_n), .frame_sync(frame_sync),
    .edge_invert(edge_invert), .data_in(data_in), .data_out_o(data_out_o)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wait_eoc(input logic v);
    int i;
    for (i = 0; i < 40 && eoc !== v; i++) @(posedge core_clk);
  endtask : wait_eoc

  task automatic finish_conv(input logic [9:0] v);
    @(posedge core_clk) conv_done <= 1'b1;
    conv_data <= v;
    @(posedge core_clk) conv_done <= 1'b0;
    wait_eoc(1'b1);
    chk(eoc, 10'h001);
  endtask : finish_conv

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : give_verdict

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  initial begin
    int i;
    sys_rst = 1'b1;
    sample_start_n = 1'b1;
    conv_done = 1'b0;
    conv_data = 10'h000;
    prev = SAC_RESULT_RST;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    #1 chk(eoc, 10'h001);
    chk(mux_addr, 10'h000);
    chk(sampling, 10'h000);
    chk(test_mode, 10'h000);
    $display("test reset done");
    repeat (4) @(posedge core_clk);
    foreach (rows[i]) begin
      host.frame(rows[i].dsp, rows[i].inv, rows[i].cmd);
      chk(host.got, prev);
      chk(data_out_oe, 10'h000);
      chk(test_mode, 10'h000);
      chk(mux_addr, rows[i].cmd);
      wait_eoc(1'b0);
      chk(eoc, 10'h000);
      repeat (5) @(posedge core_clk);
      chk(eoc, 10'h000);
      finish_conv(rows[i].res);
      prev = rows[i].res;
      $display("test frame %0d done", i);
    end
    // Extended sampling driven only by the start pin
    @(posedge core_clk) sample_start_n <= 1'b0;
    for (i = 0; i < 10 && sampling !== 1'b1; i++) @(posedge core_clk);
    chk(sampling, 10'h001);
    repeat (4) @(posedge core_clk);
    sample_start_n <= 1'b1;
    wait_eoc(1'b0);
    chk(eoc, 10'h000);
    finish_conv(10'h155);
    host.frame(1'b0, 1'b1, 4'h6);
    chk(host.got, 10'h155);
    $display("test extended sampling done");
    host.poke_invert();
    chk(data_out_oe, 10'h001);
    chk(test_mode, 10'h001);
    host.deselect();
    repeat (5) @(posedge core_clk);
    chk(test_mode, 10'h000);
    chk(data_out_oe, 10'h000);
    $display("test test mode done");
    give_verdict();
  end
endmodule : tb
